// ---- core/pw_pkg.sv ----
// ---------------------------------------------------------------------------
// Shared constants of the program-space read window.
// ---------------------------------------------------------------------------
package pw_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] PW_OFF_RD_PAGE   = 8'h00;
    localparam logic [7:0] PW_OFF_WR_PAGE   = 8'h04;
    localparam logic [7:0] PW_OFF_STATUS    = 8'h08;
    localparam logic [7:0] PW_OFF_MASK      = 8'h0c;
    localparam logic [7:0] PW_OFF_LAST_ADDR = 8'h10;

    // Page register layout.
    localparam int PW_PAGE_W       = 10;
    localparam int PW_PAGE_EN_BIT  = 9;
    localparam int PW_PAGE_HALF_BIT = 8;
    localparam int PW_PAGE_NUM_W   = 8;
    localparam logic [PW_PAGE_W-1:0] PW_RD_PAGE_RST = 10'h000;
    localparam logic [PW_PAGE_W-1:0] PW_WR_PAGE_RST = 10'h000;
    localparam logic [PW_PAGE_W-1:0] PW_PAGE_ZERO   = 10'h000;

    // Data and program address layout.
    localparam int PW_EA_W        = 16;
    localparam int PW_EA_TOP_BIT  = 15;
    localparam int PW_EA_LOW_W    = 15;
    localparam int PW_PROG_ADDR_W = 23;
    localparam int PW_PROG_WORD_W = 24;
    localparam int PW_DATA_W      = 16;
    localparam logic [7:0] PW_PHANTOM_BYTE = 8'h00;

    // Status and mask bit positions.
    localparam int PW_ST_TRAP = 0;
    localparam int PW_ST_WREF = 1;
    localparam int PW_ST_DONE = 2;
    localparam int PW_ST_W    = 3;
    localparam logic [PW_ST_W-1:0] PW_ST_RST   = 3'h0;
    localparam logic [PW_ST_W-1:0] PW_MASK_RST = 3'h0;

    // Extra read cycles through the window.
    localparam logic [1:0] PW_EXTRA_MOVE     = 2'h1;
    localparam logic [1:0] PW_EXTRA_OTHER    = 2'h2;
    localparam logic [1:0] PW_EXTRA_RPT_EDGE = 2'h2;
    localparam logic [1:0] PW_EXTRA_RPT_MID  = 2'h0;

    // AXI responses.
    localparam logic [1:0] PW_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PW_RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {PW_IDLE, PW_WAIT} pw_state_t;

endpackage

// ---- core/pw_window.sv ----
`timescale 1ns/1ps
// Contract
// - The upper 32 Kbytes of data space map onto one selectable 16K-word program page.
// - A read is redirected only when address bit 15 and page bit 9 are both one.
// - The 23-bit program address is page bits 7..0 above pointer bits 14..0.
// - Page bit 8 selects the lower (zero) or upper (one) program word half.
// - Valid pages are 200h..3FFh; 200h..2FFh lower words, 300h..3FFh upper words.
// - Lower-word pages give even program addresses from 000000h and are read only.
// - Upper-word pages give the same even program addresses from 000000h, read only, half phantom.
// - The phantom upper byte of an upper program word always reads as zero.
// - An access at or above 8000h with its page register at zero raises an address error trap.
// - Outside a repeat loop a move or double move adds one cycle, other instructions two.
// - In a repeat loop first, last, interrupt-exit and re-entry iterations add two cycles.
// - Every other repeat-loop iteration completes with no extra cycle.
module pw_window
    import pw_pkg::*;
#(
    parameter int AXI_ADDR_W = 8
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [AXI_ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      cpu_req_valid,
    input  wire logic                      cpu_req_write,
    input  wire logic [PW_EA_W-1:0]        cpu_req_ea,
    input  wire logic                      cpu_req_is_move,
    input  wire logic                      cpu_in_repeat,
    input  wire logic                      cpu_repeat_edge,
    output logic                           cpu_req_ready,
    output logic                           cpu_done,
    output logic                           cpu_hit,
    output logic [PW_DATA_W-1:0]           cpu_rdata,
    output logic                           addr_error_trap,
    output logic                           prog_req,
    output logic [PW_PROG_ADDR_W-1:0]      prog_addr,
    output logic                           prog_upper,
    input  wire logic                      prog_rvalid,
    input  wire logic [PW_PROG_WORD_W-1:0] prog_rdata,
    output logic                           irq
);

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      aw_have;
        logic                      w_have;
        logic [AXI_ADDR_W-1:0]     awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic [PW_PAGE_W-1:0]      rd_page;
        logic [PW_PAGE_W-1:0]      wr_page;
        logic [PW_ST_W-1:0]        status;
        logic [PW_ST_W-1:0]        mask;
        logic                      irq;
        pw_state_t                 state;
        logic [1:0]                wait_cnt;
        logic                      data_have;
        logic                      req_ready;
        logic                      done;
        logic                      hit;
        logic [PW_DATA_W-1:0]      rdata_cpu;
        logic                      trap;
        logic                      prog_req;
        logic [PW_PROG_ADDR_W-1:0] prog_addr;
        logic                      prog_upper;
    } pw_regs_t;

    pw_regs_t r_q;
    pw_regs_t r_d;

    // -----------------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------------

    // Merges a 10-bit field under the byte strobes of the write.
    function automatic logic [PW_PAGE_W-1:0] merge_page(
        input logic [PW_PAGE_W-1:0] old_v,
        input logic [31:0]          data,
        input logic [3:0]           strb
    );
        logic [PW_PAGE_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[PW_PAGE_W-1:8] = data[PW_PAGE_W-1:8];
        end
        return v;
    endfunction

    // Picks the 16-bit half of a program word, phantom byte forced low.
    function automatic logic [PW_DATA_W-1:0] pick_half(
        input logic [PW_PROG_WORD_W-1:0] word,
        input logic                      upper
    );
        if (upper) begin
            return {PW_PHANTOM_BYTE, word[23:16]};
        end
        return word[15:0];
    endfunction

    // -----------------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------------
    logic                 win_top;
    logic [PW_PAGE_W-1:0] sel_page;
    logic                 do_write;
    logic                 do_read;
    logic [PW_ST_W-1:0]   st_set;
    logic [PW_ST_W-1:0]   st_clr;
    logic [1:0]           extra;

    always_comb begin
        r_d      = r_q;
        st_set   = '0;
        st_clr   = '0;
        win_top  = cpu_req_ea[PW_EA_TOP_BIT];
        sel_page = cpu_req_write ? r_q.wr_page : r_q.rd_page;
        extra    = PW_EXTRA_OTHER;

        // One-cycle pulses drop after they are shown.
        r_d.done     = 1'b0;
        r_d.trap     = 1'b0;
        r_d.prog_req = 1'b0;

        // Write address and write data are taken in either order.
        if (s_axi_awvalid && r_q.awready) begin
            r_d.aw_have = 1'b1;
            r_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_q.wready) begin
            r_d.w_have = 1'b1;
            r_d.wdata  = s_axi_wdata;
            r_d.wstrb  = s_axi_wstrb;
        end

        // A write takes effect once both halves are held.
        do_write = r_q.aw_have && r_q.w_have && !r_q.bvalid;
        if (do_write) begin
            r_d.aw_have = 1'b0;
            r_d.w_have  = 1'b0;
            r_d.bvalid  = 1'b1;
            r_d.bresp   = PW_RESP_OKAY;
            unique case (r_q.awaddr[7:0])
                PW_OFF_RD_PAGE: begin
                    r_d.rd_page = merge_page(r_q.rd_page, r_q.wdata,
                                             r_q.wstrb);
                end
                PW_OFF_WR_PAGE: begin
                    r_d.wr_page = merge_page(r_q.wr_page, r_q.wdata,
                                             r_q.wstrb);
                end
                PW_OFF_STATUS: begin
                    if (r_q.wstrb[0]) begin
                        st_clr = r_q.wdata[PW_ST_W-1:0];
                    end
                end
                PW_OFF_MASK: begin
                    if (r_q.wstrb[0]) begin
                        r_d.mask = r_q.wdata[PW_ST_W-1:0];
                    end
                end
                PW_OFF_LAST_ADDR: begin
                    r_d.bresp = PW_RESP_OKAY;
                end
                default: begin
                    r_d.bresp = PW_RESP_SLVERR;
                end
            endcase
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        r_d.awready = !r_d.aw_have && !r_d.bvalid && !do_write;
        r_d.wready  = !r_d.w_have && !r_d.bvalid && !do_write;

        // Register reads answer one cycle after the address is taken.
        do_read = s_axi_arvalid && r_q.arready;
        if (do_read) begin
            r_d.rvalid = 1'b1;
            r_d.rresp  = PW_RESP_OKAY;
            r_d.rdata  = '0;
            unique case (s_axi_araddr[7:0])
                PW_OFF_RD_PAGE: begin
                    r_d.rdata[PW_PAGE_W-1:0] = r_q.rd_page;
                end
                PW_OFF_WR_PAGE: begin
                    r_d.rdata[PW_PAGE_W-1:0] = r_q.wr_page;
                end
                PW_OFF_STATUS: begin
                    r_d.rdata[PW_ST_W-1:0] = r_q.status;
                end
                PW_OFF_MASK: begin
                    r_d.rdata[PW_ST_W-1:0] = r_q.mask;
                end
                PW_OFF_LAST_ADDR: begin
                    r_d.rdata[PW_PROG_ADDR_W-1:0] = r_q.prog_addr;
                end
                default: begin
                    r_d.rresp = PW_RESP_SLVERR;
                end
            endcase
        end
        if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
        r_d.arready = !r_d.rvalid;

        // Extra cycles chosen by instruction kind and repeat position.
        if (cpu_in_repeat) begin
            extra = cpu_repeat_edge ? PW_EXTRA_RPT_EDGE
                                    : PW_EXTRA_RPT_MID;
        end else begin
            extra = cpu_req_is_move ? PW_EXTRA_MOVE
                                    : PW_EXTRA_OTHER;
        end

        // CPU access sequencer.
        unique case (r_q.state)
            PW_IDLE: begin
                if (cpu_req_valid && r_q.req_ready) begin
                    r_d.hit  = 1'b0;
                    if (win_top && (sel_page == PW_PAGE_ZERO)) begin
                        r_d.trap = 1'b1;
                        r_d.done = 1'b1;
                        st_set[PW_ST_TRAP] = 1'b1;
                    end else if (win_top && sel_page[PW_PAGE_EN_BIT]
                                 && cpu_req_write) begin
                        r_d.done = 1'b1;
                        st_set[PW_ST_WREF] = 1'b1;
                    end else if (win_top && sel_page[PW_PAGE_EN_BIT]) begin
                        // Only pages 200h..3FFh reach here.
                        r_d.state      = PW_WAIT;
                        r_d.req_ready  = 1'b0;
                        r_d.hit        = 1'b1;
                        r_d.prog_req   = 1'b1;
                        r_d.prog_addr  = {sel_page[PW_PAGE_NUM_W-1:0],
                                          cpu_req_ea[PW_EA_LOW_W-1:0]};
                        r_d.prog_upper = sel_page[PW_PAGE_HALF_BIT];
                        r_d.wait_cnt   = extra;
                        r_d.data_have  = 1'b0;
                    end else begin
                        r_d.done = 1'b1;
                    end
                end
            end
            PW_WAIT: begin
                if (prog_rvalid && !r_q.data_have) begin
                    r_d.data_have = 1'b1;
                    r_d.rdata_cpu = pick_half(prog_rdata,
                                              r_q.prog_upper);
                end
                if (r_d.data_have && (r_q.wait_cnt != 2'h0)) begin
                    r_d.wait_cnt = r_q.wait_cnt - 2'h1;
                end
                if ((r_q.wait_cnt == 2'h0) && r_d.data_have) begin
                    r_d.state     = PW_IDLE;
                    r_d.req_ready = 1'b1;
                    r_d.done      = 1'b1;
                    st_set[PW_ST_DONE] = 1'b1;
                end
            end
        endcase

        // Sticky status: a new event wins over a clear in the same cycle.
        r_d.status = (r_q.status & ~st_clr) | st_set;
        r_d.irq    = |(r_d.status & r_d.mask);
    end

    // -----------------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------------

    // Registers the whole state, synchronous active-low reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q           <= '0;
            r_q.awready   <= 1'b1;
            r_q.wready    <= 1'b1;
            r_q.arready   <= 1'b1;
            r_q.rd_page   <= PW_RD_PAGE_RST;
            r_q.wr_page   <= PW_WR_PAGE_RST;
            r_q.status    <= PW_ST_RST;
            r_q.mask      <= PW_MASK_RST;
            r_q.state     <= PW_IDLE;
            r_q.req_ready <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------

    // Every output is a field of the state register.
    assign s_axi_awready   = r_q.awready;
    assign s_axi_wready    = r_q.wready;
    assign s_axi_bresp     = r_q.bresp;
    assign s_axi_bvalid    = r_q.bvalid;
    assign s_axi_arready   = r_q.arready;
    assign s_axi_rdata     = r_q.rdata;
    assign s_axi_rresp     = r_q.rresp;
    assign s_axi_rvalid    = r_q.rvalid;
    assign cpu_req_ready   = r_q.req_ready;
    assign cpu_done        = r_q.done;
    assign cpu_hit         = r_q.hit;
    assign cpu_rdata       = r_q.rdata_cpu;
    assign addr_error_trap = r_q.trap;
    assign prog_req        = r_q.prog_req;
    assign prog_addr       = r_q.prog_addr;
    assign prog_upper      = r_q.prog_upper;
    assign irq             = r_q.irq;

endmodule

// ---- verification/pw_prog_mem.sv ----
`timescale 1ns/1ps
// Program memory stand-in: answers each read after lat cycles, lat >= 1.
module pw_prog_mem
    import pw_pkg::*;
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      prog_req,
    input  wire logic [PW_PROG_ADDR_W-1:0] prog_addr,
    input  wire logic [3:0]                lat,
    output logic                           prog_rvalid,
    output logic [PW_PROG_WORD_W-1:0]      prog_rdata
);
    logic [3:0]                cnt_q;
    logic [PW_PROG_ADDR_W-1:0] addr_q;
    logic                      go;
    logic [PW_PROG_ADDR_W-1:0] a;

    // Fires now for a prompt answer, else when the countdown ends.
    assign go = prog_req ? lat == 4'h1 : cnt_q == 4'h1;
    assign a  = prog_req ? prog_addr : addr_q;

    // Outside its valid cycle the word flips so stale data never matches.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q       <= 4'h0;
            addr_q      <= '0;
            prog_rvalid <= 1'b0;
            prog_rdata  <= 24'h0;
        end else begin
            cnt_q       <= prog_req ? lat - 4'h1 : cnt_q - 4'(cnt_q != 4'h0);
            addr_q      <= a;
            prog_rvalid <= go;
            prog_rdata  <= go ? {a[22:15], ~a[15:0]} : ~prog_rdata;
        end
    end
endmodule

// ---- verification/pw_window_sva.sv ----
`timescale 1ns/1ps
// Checks window timing and data against the taken CPU request.
module pw_window_sva
    import pw_pkg::*;
(
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic                      cpu_req_valid,
    input wire logic                      cpu_req_write,
    input wire logic [PW_EA_W-1:0]        cpu_req_ea,
    input wire logic                      cpu_req_is_move,
    input wire logic                      cpu_in_repeat,
    input wire logic                      cpu_repeat_edge,
    input wire logic                      cpu_req_ready,
    input wire logic                      cpu_done,
    input wire logic                      cpu_hit,
    input wire logic [PW_DATA_W-1:0]      cpu_rdata,
    input wire logic                      addr_error_trap,
    input wire logic                      prog_req,
    input wire logic [PW_PROG_ADDR_W-1:0] prog_addr,
    input wire logic                      prog_upper,
    input wire logic                      prog_rvalid
);
    logic take;

    // A request is taken where valid meets ready.
    assign take = cpu_req_valid && cpu_req_ready;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_addr_low: assert property (
        prog_req |-> prog_addr[14:0] == $past(cpu_req_ea[14:0]))
        else $error("program address not built from pointer");
    a_read_only: assert property (
        prog_req |-> !$past(cpu_req_write) && $past(cpu_req_ea[15]))
        else $error("program read for a write or low address");
    a_low_miss: assert property (
        take && !cpu_req_ea[15] |=> cpu_done && !cpu_hit && !prog_req)
        else $error("low address not a plain miss");
    a_trap_pulse: assert property (
        addr_error_trap |-> cpu_done && !cpu_hit && $past(cpu_req_ea[15]))
        else $error("trap without a high address access");
    a_phantom_zero: assert property (
        cpu_done && cpu_hit && prog_upper |-> cpu_rdata[15:8] == 8'h00)
        else $error("phantom byte not zero");
    a_wait_busy: assert property (
        prog_req |-> !cpu_req_ready)
        else $error("request accepted during a window read");
    a_move_extra: assert property (
        take && cpu_req_is_move && !cpu_in_repeat ##1 prog_req
        ##1 prog_rvalid && !cpu_done |=> !cpu_done ##1 cpu_done)
        else $error("move read not one extra cycle");
    a_other_extra: assert property (
        take && (cpu_in_repeat ? cpu_repeat_edge : !cpu_req_is_move)
        ##1 prog_req ##1 prog_rvalid && !cpu_done
        |=> !cpu_done ##1 !cpu_done ##1 cpu_done)
        else $error("read not two extra cycles");
    a_mid_single: assert property (
        take && cpu_in_repeat && !cpu_repeat_edge ##1 prog_req
        ##1 prog_rvalid |=> cpu_done)
        else $error("mid loop read not single cycle");
endmodule

bind pw_window pw_window_sva pw_window_sva_i (
    .aclk, .aresetn, .cpu_req_valid, .cpu_req_write, .cpu_req_ea,
    .cpu_req_is_move, .cpu_in_repeat, .cpu_repeat_edge, .cpu_req_ready,
    .cpu_done, .cpu_hit, .cpu_rdata, .addr_error_trap, .prog_req,
    .prog_addr, .prog_upper, .prog_rvalid
);

// ---- verification/pw_window_tb.sv ----
`timescale 1ns/1ps
// Drivers queue expected notes; the monitor compares them on completion.
module pw_window_tb;
    import pw_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, cpu_req_valid, cpu_req_write;
    logic        cpu_req_is_move, cpu_in_repeat, cpu_repeat_edge, cpu_hit;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, cpu_req_ready, cpu_done, prog_upper, irq;
    logic        addr_error_trap, prog_req, prog_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, lat;
    logic [15:0] cpu_req_ea, cpu_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
    logic [22:0] prog_addr;
    logic [23:0] prog_rdata;
    logic [33:0] cq[$], rq[$], n;
    logic [9:0]  tbl[6] = '{10'h000, 10'h0ff, 10'h200,
                            10'h2ff, 10'h300, 10'h3ff};
    int          errors, tests_run;
    time         t_take;

    pw_window pw_window_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req_valid,
        .cpu_req_write, .cpu_req_ea, .cpu_req_is_move, .cpu_in_repeat,
        .cpu_repeat_edge, .cpu_req_ready, .cpu_done, .cpu_hit, .cpu_rdata,
        .addr_error_trap, .prog_req, .prog_addr, .prog_upper, .prog_rvalid,
        .prog_rdata, .irq);
    pw_prog_mem pw_prog_mem_i (.aclk, .aresetn, .prog_req, .prog_addr, .lat,
        .prog_rvalid, .prog_rdata);

    // Free-running 250 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Cuts a hung run short.
    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(string what, logic [33:0] exp, logic [33:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Note layout: cycles (0 = unchecked), trap, hit, read data.
    function automatic logic [33:0] note(logic [9:0] pg, logic w,
                                         logic [15:0] ea, logic [1:0] k,
                                         logic fast);
        logic [22:0] a;
        logic [23:0] d;
        logic [3:0]  x;
        a = {pg[7:0], ea[14:0]};
        d = {a[22:15], ~a[15:0]};
        x = k == 2'h0 ? 4'h1 : (k == 2'h3 ? 4'h0 : 4'h2);
        if (ea[15] && pg == 10'h0) return {4'h1, 2'b10, 16'h0};
        if (!ea[15] || !pg[9] || w) return {4'h1, 2'b00, 16'h0};
        return {fast ? 4'h3 + x : 4'h0, 2'b01,
                pg[8] ? {8'h00, d[23:16]} : d[15:0]};
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
                      logic [1:0] r);
        bit aw, w;
        bq.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(logic [7:0] a, logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // k: 0 move, 1 other, 2 repeat boundary, 3 repeat middle.
    task automatic cpu(logic w, logic [15:0] ea, logic [1:0] k,
                       logic [33:0] e);
        cq.push_back(e);
        cpu_req_write   <= w;
        cpu_req_ea      <= ea;
        cpu_req_is_move <= k != 2'h1;
        cpu_in_repeat   <= k[1];
        cpu_repeat_edge <= k == 2'h2;
        cpu_req_valid   <= 1'b1;
        do @(posedge aclk); while (!cpu_req_ready);
        t_take = $time;
        cpu_req_valid <= 1'b0;
        cpu_req_ea    <= ~ea;
        do @(posedge aclk); while (!cpu_done);
    endtask

    task automatic irq_is(logic v);
        @(posedge aclk);
        #1;
        check("irq", v, irq);
    endtask

    // Compares each completed result with the oldest note of its kind.
    always @(posedge aclk) begin
        if (aresetn && cpu_done) begin
            n = cq.pop_front();
            check("trap", n[17], addr_error_trap);
            check("hit", n[16], cpu_hit);
            if (n[16]) check("cpu_rdata", n[15:0], cpu_rdata);
            if (n[21:18] != 4'h0) check("cycles", n[21:18],
                34'(($time - t_take) / 4));
        end
        if (s_axi_rvalid && s_axi_rready)
            check("rdata", rq.pop_front(),
                  {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", bq.pop_front(), s_axi_bresp);
    end

    // Main sequence: reset values, page sweep, then interrupts.
    initial begin
        logic [9:0]  rp, wp;
        logic [15:0] ea;
        logic [3:0]  l;
        logic        w;
        void'($urandom(24235));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, cpu_req_valid, cpu_req_write} = '0;
        {cpu_req_is_move, cpu_in_repeat, cpu_repeat_edge} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        cpu_req_ea = 16'h0;
        lat = 4'h1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) rd(8'(4 * i), {PW_RESP_OKAY, 32'h0});
        rd(8'h14, {PW_RESP_SLVERR, 32'h0});
        wr(8'h14, 32'h3ff, 4'hf, PW_RESP_SLVERR);
        for (int i = 0; i < 42; i++) begin
            rp = i % 7 == 6 ? 10'h200 | 10'($urandom % 512) : tbl[i % 7];
            wp = tbl[(i + 3) % 6];
            w  = i % 5 == 4;
            ea = {i % 6 != 5, 15'($urandom)};
            l  = i < 21 ? 4'h1 : 4'h1 + 4'($urandom % 4);
            lat <= l;
            wr(PW_OFF_RD_PAGE, 32'(rp), 4'h3, PW_RESP_OKAY);
            wr(PW_OFF_WR_PAGE, 32'(wp), 4'h3, PW_RESP_OKAY);
            rd(PW_OFF_RD_PAGE, {PW_RESP_OKAY, 22'h0, rp});
            cpu(w, ea, 2'(i), note(w ? wp : rp, w, ea, 2'(i), l == 4'h1));
            if (!w && ea[15] && rp[9])
                rd(PW_OFF_LAST_ADDR, {PW_RESP_OKAY, 9'h0, rp[7:0], ea[14:0]});
        end
        rd(PW_OFF_STATUS, {PW_RESP_OKAY, 29'h0, 3'h7});
        wr(PW_OFF_MASK, 32'h4, 4'h1, PW_RESP_OKAY);
        irq_is(1'b1);
        wr(PW_OFF_STATUS, 32'h4, 4'h1, PW_RESP_OKAY);
        irq_is(1'b0);
        rd(PW_OFF_STATUS, {PW_RESP_OKAY, 29'h0, 3'h3});
        wr(PW_OFF_MASK, 32'h1, 4'h1, PW_RESP_OKAY);
        wr(PW_OFF_STATUS, 32'h7, 4'h1, PW_RESP_OKAY);
        wr(PW_OFF_RD_PAGE, 32'h0, 4'h3, PW_RESP_OKAY);
        lat <= 4'h1;
        cpu(1'b0, 16'h8000, 2'h0, note(10'h0, 1'b0, 16'h8000, 2'h0, 1'b1));
        irq_is(1'b1);
        end_of_test();
    end
endmodule
